// [adc_ctrl.sv]
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"
module adc_ctrl #(
  parameter int ADDR_W = 8
) (
  input  wire logic              sys_clk_i,          // 25 MHz clock
  input  wire logic              reset_i,            // Sync reset, high
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,     // Write address
  input  wire logic              s_axi_awvalid_i,    // Write address valid
  output logic                   s_axi_awready_o,    // Write address ready
  input  wire logic [31:0]       s_axi_wdata_i,      // Write data
  input  wire logic [3:0]        s_axi_wstrb_i,      // Write strobes
  input  wire logic              s_axi_wvalid_i,     // Write data valid
  output logic                   s_axi_wready_o,     // Write data ready
  output logic [1:0]             s_axi_bresp_o,      // Write response
  output logic                   s_axi_bvalid_o,     // Write response valid
  input  wire logic              s_axi_bready_i,     // Write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,     // Read address
  input  wire logic              s_axi_arvalid_i,    // Read address valid
  output logic                   s_axi_arready_o,    // Read address ready
  output logic [31:0]            s_axi_rdata_o,      // Read data
  output logic [1:0]             s_axi_rresp_o,      // Read response
  output logic                   s_axi_rvalid_o,     // Read data valid
  input  wire logic              s_axi_rready_i,     // Read data ready
  input  wire logic              rc_osc_i,           // Internal RC osc pin
  input  wire logic              comp_i,             // SAR comparator out
  input  wire logic              charge_time_trig_i, // Charge unit trigger
  input  wire logic              capture_trig_i,     // Second CCP trigger
  output logic                   converter_power_o,  // Analog power on
  output logic [4:0]             channel_select_o,   // Input mux code
  output logic [1:0]             pos_ref_select_o,   // Upper ref code
  output logic [1:0]             neg_ref_select_o,   // Lower ref code
  output logic                   sample_o,           // Hold cap on input
  output logic                   convert_o,          // Conversion phase
  output logic                   discharge_o,        // Hold cap discharge
  output logic [9:0]             dac_code_o,         // SAR trial code
  output logic                   irq_o,              // Done interrupt
  output logic                   conv_done_priority_o // Priority level
);
  adc_ctrl_pkg::seq_state_t state_ff;

  logic              aw_held_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic              w_held_ff;
  logic [7:0]        wdata_ff;
  logic              wlane_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [7:0]        rdata_ff;
  logic [1:0]        rresp_ff;
  logic              rc_s1_ff, rc_s2_ff, rc_s3_ff;
  logic              cmp_s1_ff, cmp_s2_ff;
  logic [4:0]        chs_ff;
  logic              en_ff, go_ff;
  logic              tsel_ff;
  logic [1:0]        pref_ff, nref_ff;
  logic              just_ff;
  logic [2:0]        acq_ff, cs_ff;
  logic [7:0]        res_hi_ff, res_lo_ff;
  logic              flag_ff, ie_ff, ip_ff, md_ff;
  logic [4:0]        tad_ff;
  logic [3:0]        idx_ff;
  logic [9:0]        sar_ff;
  logic [2:0]        dly_ff;
  logic              tick;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == `OFS_CTRL0) || (a == `OFS_CTRL1) || (a == `OFS_CTRL2) ||
             (a == `OFS_RES_HI) || (a == `OFS_RES_LO) || (a == `OFS_FLAG) ||
             (a == `OFS_IENA) || (a == `OFS_IPRI) || (a == `OFS_MDIS);
  endfunction

  function automatic logic [4:0] acq_tads(input logic [2:0] c);
    case (c)
      3'h0:    acq_tads = 5'h00;
      3'h1:    acq_tads = 5'h02;
      3'h2:    acq_tads = 5'h04;
      3'h3:    acq_tads = 5'h06;
      3'h4:    acq_tads = 5'h08;
      3'h5:    acq_tads = 5'h0C;
      3'h6:    acq_tads = 5'h10;
      default: acq_tads = 5'h14;
    endcase
  endfunction

  // AXI write side
  wire ctl_rst  = reset_i | md_ff;
  wire wr_fire  = aw_held_ff & w_held_ff & ~bvalid_ff;
  wire wr_ok    = mapped(awaddr_ff);
  wire wr_en    = wr_fire & wlane_ff;
  wire wr_c0    = wr_en & (awaddr_ff == `OFS_CTRL0);
  wire wr_c1    = wr_en & (awaddr_ff == `OFS_CTRL1);
  wire wr_c2    = wr_en & (awaddr_ff == `OFS_CTRL2);
  wire wr_hi    = wr_en & (awaddr_ff == `OFS_RES_HI);
  wire wr_lo    = wr_en & (awaddr_ff == `OFS_RES_LO);
  wire wr_ie    = wr_en & (awaddr_ff == `OFS_IENA);
  wire wr_ip    = wr_en & (awaddr_ff == `OFS_IPRI);
  wire wr_md    = wr_en & (awaddr_ff == `OFS_MDIS);
  wire rd_fire  = s_axi_arvalid_i & ~rvalid_ff;

  assign s_axi_awready_o = ~aw_held_ff;
  assign s_axi_wready_o  = ~w_held_ff;
  assign s_axi_bvalid_o  = bvalid_ff;
  assign s_axi_bresp_o   = bresp_ff;
  assign s_axi_arready_o = ~rvalid_ff;
  assign s_axi_rvalid_o  = rvalid_ff;
  assign s_axi_rresp_o   = rresp_ff;
  assign s_axi_rdata_o   = {24'h000000, rdata_ff};

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= '0;
      w_held_ff  <= 1'b0;
      wdata_ff   <= 8'h00;
      wlane_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i && !aw_held_ff)
      begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr_i;
      end
      else if (wr_fire)
        aw_held_ff <= 1'b0;
      if (s_axi_wvalid_i && !w_held_ff)
      begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata_i[7:0];
        wlane_ff  <= s_axi_wstrb_i[0];
      end
      else if (wr_fire)
        w_held_ff <= 1'b0;
      if (wr_fire)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready_i)
        bvalid_ff <= 1'b0;
    end
  end

  wire [7:0] rd_c0 = {1'b0, chs_ff, go_ff, en_ff};
  wire [7:0] rd_c1 = {tsel_ff, 3'h0, pref_ff, nref_ff};
  wire [7:0] rd_c2 = {just_ff, 1'b0, acq_ff, cs_ff};
  wire [7:0] rd_fl = {1'b0, flag_ff, 6'h00};
  wire [7:0] rd_ie = {1'b0, ie_ff, 6'h00};
  wire [7:0] rd_ip = {1'b0, ip_ff, 6'h00};
  wire [7:0] rd_md = {5'h00, md_ff, 2'h0};
  wire [ADDR_W-1:0] ra = s_axi_araddr_i;
  wire [7:0] rd_mux =
    (ra == `OFS_CTRL0)  ? rd_c0 :
    (ra == `OFS_CTRL1)  ? rd_c1 :
    (ra == `OFS_CTRL2)  ? rd_c2 :
    (ra == `OFS_RES_HI) ? res_hi_ff :
    (ra == `OFS_RES_LO) ? res_lo_ff :
    (ra == `OFS_FLAG)   ? rd_fl :
    (ra == `OFS_IENA)   ? rd_ie :
    (ra == `OFS_IPRI)   ? rd_ip :
    (ra == `OFS_MDIS)   ? rd_md : 8'h00;
  wire rd_flag = rd_fire & (ra == `OFS_FLAG);

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 8'h00;
      rresp_ff  <= `RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_mux;
      rresp_ff  <= mapped(ra) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready_i)
      rvalid_ff <= 1'b0;
  end

  // Pin inputs, two stages before use
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      rc_s1_ff  <= 1'b0;
      rc_s2_ff  <= 1'b0;
      rc_s3_ff  <= 1'b0;
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
    end
    else
    begin
      rc_s1_ff  <= rc_osc_i;
      rc_s2_ff  <= rc_s1_ff;
      rc_s3_ff  <= rc_s2_ff;
      cmp_s1_ff <= comp_i;
      cmp_s2_ff <= cmp_s1_ff;
    end
  end

  // Sequencer decode
  wire use_rc  = (cs_ff == 3'h3) || (cs_ff == 3'h7);
  wire busy    = (state_ff == adc_ctrl_pkg::ST_DELAY) ||
                 (state_ff == adc_ctrl_pkg::ST_ACQ) ||
                 (state_ff == adc_ctrl_pkg::ST_CONV);
  wire trig_src = tsel_ff ? charge_time_trig_i : capture_trig_i;
  wire trig    = trig_src & en_ff & ~go_ff;
  wire sw_go   = wr_c0 & wdata_ff[`BIT_GO] & en_ff & ~go_ff;
  wire sw_stop = wr_c0 & ~wdata_ff[`BIT_GO] & go_ff;
  wire last    = (idx_ff == 4'h0);
  wire done    = (state_ff == adc_ctrl_pkg::ST_CONV) & tick & last & go_ff;
  wire [4:0] acq_n  = acq_tads(acq_ff);
  wire [9:0] sar_kp = sar_ff & ~({9'h000, ~cmp_s2_ff} << idx_ff);
  wire [9:0] result = sar_kp;
  wire nxt_go  = (go_ff & ~done & ~sw_stop & en_ff) | sw_go | trig;
  wire nxt_flag = done | (flag_ff & ~rd_flag);

  // Control registers; module disable acts as reset
  always_ff @(posedge sys_clk_i)
  begin
    if (ctl_rst)
    begin
      {chs_ff, en_ff} <= 6'h00;
      tsel_ff <= 1'b0;
      pref_ff <= 2'h0;
      nref_ff <= 2'h0;
      just_ff <= 1'b0;
      acq_ff  <= 3'h0;
      cs_ff   <= 3'h0;
      go_ff   <= 1'b0;
      flag_ff <= 1'b0;
    end
    else
    begin
      if (wr_c0)
      begin
        chs_ff <= wdata_ff[`BIT_CHS_LO +: 5];
        en_ff  <= wdata_ff[`BIT_ENABLE];
      end
      if (wr_c1)
      begin
        tsel_ff <= wdata_ff[`BIT_TRIG_SEL];
        pref_ff <= wdata_ff[`BIT_PREF_LO +: 2];
        nref_ff <= wdata_ff[`BIT_NREF_LO +: 2];
      end
      if (wr_c2)
      begin
        just_ff <= wdata_ff[`BIT_JUSTIFY];
        acq_ff  <= wdata_ff[`BIT_ACQ_LO +: 3];
        cs_ff   <= wdata_ff[`BIT_CS_LO +: 3];
      end
      go_ff   <= nxt_go;
      flag_ff <= nxt_flag;
    end
  end

  // Interrupt controls survive module disable
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      ie_ff <= 1'b0;
      ip_ff <= 1'b0;
      md_ff <= 1'b0;
    end
    else
    begin
      if (wr_ie)
        ie_ff <= wdata_ff[`BIT_DONE];
      if (wr_ip)
        ip_ff <= wdata_ff[`BIT_DONE];
      if (wr_md)
        md_ff <= wdata_ff[`BIT_MDIS];
    end
  end

  // Results keep their content through reset and aborts
  always_ff @(posedge sys_clk_i)
  begin
    if (done)
    begin
      if (just_ff)
      begin
        res_hi_ff <= {6'h00, result[9:8]};
        res_lo_ff <= result[7:0];
      end
      else
      begin
        res_hi_ff <= result[9:2];
        res_lo_ff <= {result[1:0], 6'h00};
      end
    end
    else
    begin
      if (wr_hi)
        res_hi_ff <= wdata_ff;
      if (wr_lo)
        res_lo_ff <= wdata_ff;
    end
  end

  conv_clock_gen u_clk (
    .sys_clk_i (sys_clk_i),
    .reset_i   (ctl_rst),
    .run_i     (en_ff),
    .sel_i     (cs_ff),
    .rc_rise_i (rc_s2_ff & ~rc_s3_ff),
    .tick_o    (tick)
  );

  // Conversion sequencer
  always_ff @(posedge sys_clk_i)
  begin
    if (ctl_rst || !en_ff)
    begin
      state_ff <= adc_ctrl_pkg::ST_IDLE;
      tad_ff   <= 5'h00;
      idx_ff   <= 4'h9;
      sar_ff   <= 10'h000;
      dly_ff   <= 3'h0;
    end
    else
    begin
      case (state_ff)
        adc_ctrl_pkg::ST_IDLE:
          if (go_ff)
          begin
            dly_ff   <= 3'h1;
            tad_ff   <= 5'h00;
            idx_ff   <= 4'h9;
            sar_ff   <= 10'h200;
            state_ff <= use_rc ? adc_ctrl_pkg::ST_DELAY : adc_ctrl_pkg::ST_ACQ;
          end
        adc_ctrl_pkg::ST_DELAY:
          if (!go_ff)
            state_ff <= adc_ctrl_pkg::ST_DISCH;
          else if (dly_ff == `INSTR_CYCLES)
            state_ff <= adc_ctrl_pkg::ST_ACQ;
          else
            dly_ff <= dly_ff + 3'h1;
        adc_ctrl_pkg::ST_ACQ:
          // Discharge counts from zero even when cut short mid-acquisition
          if (!go_ff)
          begin
            tad_ff   <= 5'h00;
            state_ff <= adc_ctrl_pkg::ST_DISCH;
          end
          else if (tad_ff == acq_n)
          begin
            tad_ff   <= 5'h00;
            state_ff <= adc_ctrl_pkg::ST_CONV;
          end
          else if (tick)
            tad_ff <= tad_ff + 5'h01;
        adc_ctrl_pkg::ST_CONV:
          if (!go_ff)
            state_ff <= adc_ctrl_pkg::ST_DISCH;
          else if (tick)
          begin
            // Comparator settles one period per trial bit
            if (last)
              state_ff <= adc_ctrl_pkg::ST_DISCH;
            else
            begin
              sar_ff <= sar_kp | (10'h001 << (idx_ff - 4'h1));
              idx_ff <= idx_ff - 4'h1;
            end
          end
        adc_ctrl_pkg::ST_DISCH:
          if (tad_ff == `DISCH_TADS)
          begin
            tad_ff   <= 5'h00;
            state_ff <= adc_ctrl_pkg::ST_IDLE;
          end
          else if (tick)
            tad_ff <= tad_ff + 5'h01;
        default:
          state_ff <= adc_ctrl_pkg::ST_IDLE;
      endcase
    end
  end

  assign converter_power_o    = en_ff & ~md_ff;
  assign channel_select_o     = chs_ff;
  assign pos_ref_select_o     = pref_ff;
  assign neg_ref_select_o     = nref_ff;
  assign sample_o             = converter_power_o & ~busy & ~discharge_o |
                                (state_ff == adc_ctrl_pkg::ST_ACQ) |
                                (state_ff == adc_ctrl_pkg::ST_DELAY);
  assign convert_o            = (state_ff == adc_ctrl_pkg::ST_CONV);
  assign discharge_o          = (state_ff == adc_ctrl_pkg::ST_DISCH);
  assign dac_code_o           = sar_ff;
  assign irq_o                = flag_ff & ie_ff;
  assign conv_done_priority_o = ip_ff;
endmodule // adc_ctrl

// [adc_ctrl_regs.svh]
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH
// Functional notes
// - Control 0 bits 6:2 pick input 0-27, temp diode, charge unit, DAC, fixed ref
// - Control 0 bit 0 powers the converter; cleared means off, no current
// - Control 1 bit 7 picks trigger: 1 charge-time unit, 0 second capture/compare
// - Control 1 bits 3:2 pick upper reference: supply, ref pin, fixed ref; 11 reserved
// - Acquisition code 000-111 gives 0,2,4,6,8,12,16,20 conversion clock periods
// - With RC clock, conversion starts one instruction cycle after the start bit
// - Left justified: result 9:2 in high byte, 1:0 in low byte bits 7:6
// - Right justified: result 9:8 in high byte bits 1:0, 7:0 in low byte
// - Hold capacitor is discharged after every conversion
// - Done flag, enable and priority sit in bit 6 of their registers
// - Converter module-disable sits in bit 2 of module disable register 1
// - On finish: clear start bit, set done flag, load result pair
// - Clearing start bit early aborts and keeps the previous result
// - Special trigger starts acquisition only while the converter is enabled
// - Module disable holds the converter in reset and stops its clock
`define OFS_CTRL0       8'h00
`define OFS_CTRL1       8'h04
`define OFS_CTRL2       8'h08
`define OFS_RES_HI      8'h0C
`define OFS_RES_LO      8'h10
`define OFS_FLAG        8'h14
`define OFS_IENA        8'h18
`define OFS_IPRI        8'h1C
`define OFS_MDIS        8'h20
`define BIT_ENABLE      0
`define BIT_GO          1
`define BIT_CHS_LO      2
`define BIT_TRIG_SEL    7
`define BIT_PREF_LO     2
`define BIT_NREF_LO     0
`define BIT_JUSTIFY     7
`define BIT_ACQ_LO      3
`define BIT_CS_LO       0
`define BIT_DONE        6
`define BIT_MDIS        2
`define CTRL_RESET      8'h00
`define INSTR_CYCLES    3'h4
`define DISCH_TADS      5'h02
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// [adc_ctrl_pkg.sv]
package adc_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DELAY,
    ST_ACQ,
    ST_CONV,
    ST_DISCH
  } seq_state_t;
endpackage

// [conv_clock_gen.sv]
`timescale 1ns/1ps
module conv_clock_gen (
  input  wire logic       sys_clk_i,  // System clock
  input  wire logic       reset_i,    // Sync reset, high
  input  wire logic       run_i,      // Converter powered
  input  wire logic [2:0] sel_i,      // Clock select code
  input  wire logic       rc_rise_i,  // Synchronised RC edge
  output logic            tick_o      // One pulse per period
);
  logic [5:0] cnt_ff;
  logic       tick_ff;
  // Divider limit minus one; zero marks the RC source
  function automatic logic [5:0] div_lim(input logic [2:0] s);
    case (s)
      3'h0:    div_lim = 6'h01;
      3'h1:    div_lim = 6'h07;
      3'h2:    div_lim = 6'h1F;
      3'h4:    div_lim = 6'h03;
      3'h5:    div_lim = 6'h0F;
      3'h6:    div_lim = 6'h3F;
      default: div_lim = 6'h00;
    endcase
  endfunction
  wire [5:0] lim    = div_lim(sel_i);
  wire       use_rc = (lim == 6'h00);
  wire       wrap   = (cnt_ff >= lim);
  // Stopped clock
  // module disable
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i || !run_i)
    begin
      cnt_ff  <= 6'h00;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= (use_rc || wrap) ? 6'h00 : cnt_ff + 6'h01;
      tick_ff <= use_rc ? rc_rise_i : wrap;
    end
  end
  assign tick_o = tick_ff;
endmodule // conv_clock_gen

// [adc_ctrl_assertions.sv]
`timescale 1ns/1ps
module adc_ctrl_assertions #(
  parameter int ADDR_W = 8
) (
  input wire logic              sys_clk_i,         // Clock
  input wire logic              reset_i,           // Sync reset
  input wire logic              s_axi_awvalid_i,   // AW valid
  input wire logic              s_axi_awready_o,   // AW ready
  input wire logic              s_axi_wvalid_i,    // W valid
  input wire logic              s_axi_wready_o,    // W ready
  input wire logic              s_axi_bvalid_o,    // B valid
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,    // AR address
  input wire logic              s_axi_arvalid_i,   // AR valid
  input wire logic              s_axi_arready_o,   // AR ready
  input wire logic [31:0]       s_axi_rdata_o,     // R data
  input wire logic [1:0]        s_axi_rresp_o,     // R response
  input wire logic              s_axi_rvalid_o,    // R valid
  input wire logic              s_axi_rready_i,    // R ready
  input wire logic              converter_power_o, // Analog power
  input wire logic              sample_o,          // Sampling
  input wire logic              convert_o,         // Converting
  input wire logic              discharge_o        // Discharging
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rd_taken; s_axi_arvalid_i && s_axi_arready_o; endsequence
  // Two cycles off so a sequencer one cycle behind the register is not flagged
  sequence s_power_off; !converter_power_o [*2]; endsequence

  property p_write_resp; s_wr_taken |-> ##[1:2] s_axi_bvalid_o; endproperty
  a_write_resp: assert property (p_write_resp) else $error("write response late");
  property p_read_answer; s_rd_taken |=> s_axi_rvalid_o; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");
  property p_read_release; s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o; endproperty
  a_read_release: assert property (p_read_release) else $error("read data not released");
  property p_unmapped;
    s_rd_taken and (s_axi_araddr_i > 8'h23) |=> s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_upper_zero; s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("unused read bits set");
  property p_phase_excl; $onehot0({sample_o, convert_o, discharge_o}); endproperty
  a_phase_excl: assert property (p_phase_excl) else $error("phases overlap");
  property p_conv_disch; $fell(convert_o) && converter_power_o |-> discharge_o; endproperty
  a_conv_disch: assert property (p_conv_disch) else $error("no discharge after conversion");
  property p_power_off; s_power_off |-> !sample_o && !convert_o && !discharge_o; endproperty
  a_power_off: assert property (p_power_off) else $error("activity while off");
  property p_acq_first; $rose(convert_o) |-> $past(sample_o); endproperty
  a_acq_first: assert property (p_acq_first) else $error("conversion without sampling");
endmodule // adc_ctrl_assertions

bind adc_ctrl adc_ctrl_assertions #(.ADDR_W(ADDR_W)) adc_ctrl_assertions_i (
  .sys_clk_i, .reset_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
  .s_axi_bvalid_o, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
  .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .converter_power_o, .sample_o, .convert_o,
  .discharge_o
);

// [adc_ctrl_test.sv]
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"
module adc_ctrl_test;
  logic        sys_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        rc_osc_i = 1'b0;
  logic        comp_i = 1'b0, charge_time_trig_i = 1'b0, capture_trig_i = 1'b0;
  logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h00000000, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i = 4'hF;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, pos_ref_select_o, neg_ref_select_o;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic        converter_power_o, sample_o, convert_o, discharge_o, irq_o, conv_done_priority_o;
  logic [4:0]  channel_select_o;
  logic [9:0]  dac_code_o;
  int          error_cnt = 0, check_count = 0, ta0, ta, tc;

  adc_ctrl adc_ctrl_i (
    .sys_clk_i, .reset_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
    .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .rc_osc_i, .comp_i, .charge_time_trig_i,
    .capture_trig_i, .converter_power_o, .channel_select_o, .pos_ref_select_o,
    .neg_ref_select_o, .sample_o, .convert_o, .discharge_o, .dac_code_o, .irq_o,
    .conv_done_priority_o
  );

  initial forever #20 sys_clk_i = ~sys_clk_i;
  // Free-running stand-in for the 600 kHz RC oscillator, unrelated in phase
  initial forever #833 rc_osc_i = ~rc_osc_i;

  task automatic end_of_test;
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask

  // Tick phase of the divider may shift a span by a cycle at each end
  task automatic chk_time(input int got, input int exp);
    check_count++;
    if (got < exp - 2 || got > exp + 2)
    begin
      $display("CHECK FAILED at %0t: span %0d expected %0d", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge sys_clk_i);
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= {24'h000000, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    do
    begin
      @(posedge sys_clk_i);
      if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
    end
    while (s_axi_bvalid_o !== 1'b1);
    r = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk_i);
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    do
    begin
      @(posedge sys_clk_i);
      if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
    end
    while (s_axi_rvalid_o !== 1'b1);
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk_val(r, `RESP_OKAY);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk_val(r, `RESP_OKAY);
    chk_val(d & {24'h000000, m}, {24'h000000, e});
  endtask

  task automatic wait_quiet;
    repeat (2) @(posedge sys_clk_i);
    while (convert_o === 1'b1 || discharge_o === 1'b1)
      @(posedge sys_clk_i);
  endtask

  task automatic pulse(input logic ct);
    @(posedge sys_clk_i);
    charge_time_trig_i <= ct;
    capture_trig_i     <= !ct;
    @(posedge sys_clk_i);
    charge_time_trig_i <= 1'b0;
    capture_trig_i     <= 1'b0;
  endtask

  task automatic run_conv(input logic [7:0] c2, input logic ie);
    wr(`OFS_CTRL2, c2);
    wr(`OFS_CTRL0, 8'h01);
    wr(`OFS_CTRL0, 8'h03);
    ta = 0;
    tc = 0;
    while (convert_o !== 1'b1)
    begin
      @(posedge sys_clk_i);
      ta++;
    end
    while (convert_o === 1'b1)
    begin
      @(posedge sys_clk_i);
      tc++;
    end
    repeat (2) @(posedge sys_clk_i);
    chk_val(irq_o, ie);
    rd(`OFS_FLAG, 8'hFF, 8'h40);
    rd(`OFS_CTRL0, 8'h02, 8'h00);
    chk_val(irq_o, 1'b0);
    wait_quiet;
  endtask

  task automatic s_regs;
    logic [7:0]  ofs [7] = '{`OFS_CTRL0, `OFS_CTRL1, `OFS_CTRL2, `OFS_FLAG, `OFS_IENA,
                             `OFS_IPRI, `OFS_MDIS};
    logic [31:0] d;
    logic [1:0]  r;
    for (int k = 0; k < 7; k++) rd(ofs[k], 8'hFF, 8'h00);
    axi_rd(8'h24, d, r);
    chk_val(d, 32'h00000000);
    chk_val(r, `RESP_SLVERR);
    axi_wr(8'h24, 8'h5A, r);
    chk_val(r, `RESP_SLVERR);
    wr(`OFS_CTRL0, 8'hFC);
    rd(`OFS_CTRL0, 8'hFF, 8'h7C);
    wr(`OFS_CTRL1, 8'hFF);
    rd(`OFS_CTRL1, 8'hFF, 8'h8F);
    chk_val({pos_ref_select_o, neg_ref_select_o}, 4'hF);
    wr(`OFS_CTRL2, 8'hFF);
    rd(`OFS_CTRL2, 8'hFF, 8'hBF);
    wr(`OFS_FLAG, 8'hFF);
    rd(`OFS_FLAG, 8'hFF, 8'h00);
    wr(`OFS_IPRI, 8'hFF);
    rd(`OFS_IPRI, 8'hFF, 8'h40);
    chk_val(conv_done_priority_o, 1'b1);
    for (int c = 0; c < 32; c++)
    begin
      wr(`OFS_CTRL0, {1'b0, c[4:0], 2'b00});
      chk_val(channel_select_o, c[4:0]);
    end
    wr(`OFS_CTRL1, 8'h00);
    wr(`OFS_IPRI, 8'h00);
    chk_val(conv_done_priority_o, 1'b0);
  endtask

  task automatic s_timing;
    int acq [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    int dv [8] = '{2, 8, 32, 0, 4, 16, 64, 0};
    wr(`OFS_IENA, 8'hFF);
    rd(`OFS_IENA, 8'hFF, 8'h40);
    comp_i <= 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      run_conv({2'b00, k[2:0], 3'b000}, 1'b1);
      if (k == 0) ta0 = ta;
      chk_time(ta - ta0, 2 * acq[k]);
    end
    for (int k = 0; k < 8; k++)
    begin
      // Divided clocks acquire two periods so conversion starts on a tick
      run_conv({4'h0, (dv[k] != 0), k[2:0]}, 1'b1);
      if (dv[k] != 0)
        chk_time(tc, 10 * dv[k]);
      else
        chk_time(ta - ta0, `INSTR_CYCLES);
    end
  endtask

  task automatic s_results;
    run_conv(8'h00, 1'b1);
    chk_val(dac_code_o, 32'h000003FF);
    rd(`OFS_RES_HI, 8'hFF, 8'hFF);
    rd(`OFS_RES_LO, 8'hC0, 8'hC0);
    comp_i <= 1'b0;
    run_conv(8'h80, 1'b1);
    rd(`OFS_RES_HI, 8'h03, 8'h00);
    rd(`OFS_RES_LO, 8'hFF, 8'h00);
    comp_i <= 1'b1;
    wr(`OFS_IENA, 8'h00);
    run_conv(8'h80, 1'b0);
    rd(`OFS_RES_HI, 8'h03, 8'h03);
    rd(`OFS_RES_LO, 8'hFF, 8'hFF);
    comp_i <= 1'b0;
    wr(`OFS_CTRL2, 8'hBE);
    wr(`OFS_CTRL0, 8'h03);
    repeat (50) @(posedge sys_clk_i);
    wr(`OFS_CTRL0, 8'h01);
    wait_quiet;
    rd(`OFS_FLAG, 8'hFF, 8'h00);
    rd(`OFS_RES_HI, 8'h03, 8'h03);
    rd(`OFS_RES_LO, 8'hFF, 8'hFF);
  endtask

  task automatic s_trigger;
    wr(`OFS_CTRL1, 8'h80);
    wr(`OFS_CTRL0, 8'h00);
    pulse(1'b1);
    rd(`OFS_CTRL0, 8'h02, 8'h00);
    wr(`OFS_CTRL0, 8'h01);
    pulse(1'b0);
    rd(`OFS_CTRL0, 8'h02, 8'h00);
    pulse(1'b1);
    rd(`OFS_CTRL0, 8'h02, 8'h02);
    wr(`OFS_CTRL0, 8'h01);
    wait_quiet;
    wr(`OFS_CTRL1, 8'h00);
    pulse(1'b0);
    rd(`OFS_CTRL0, 8'h02, 8'h02);
    wr(`OFS_CTRL0, 8'h01);
    wait_quiet;
  endtask

  task automatic s_disable;
    wr(`OFS_CTRL1, 8'h8F);
    chk_val(converter_power_o, 1'b1);
    wr(`OFS_MDIS, 8'h04);
    chk_val(converter_power_o, 1'b0);
    rd(`OFS_MDIS, 8'hFF, 8'h04);
    rd(`OFS_CTRL1, 8'hFF, 8'h00);
    wr(`OFS_MDIS, 8'h00);
    rd(`OFS_CTRL0, 8'hFF, 8'h00);
    chk_val(converter_power_o, 1'b0);
  endtask

  initial
  begin
    repeat (30000) @(posedge sys_clk_i);
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    error_cnt++;
    end_of_test;
  end

  initial
  begin
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    s_regs;
    s_timing;
    s_results;
    s_trigger;
    s_disable;
    end_of_test;
  end
endmodule // adc_ctrl_test
